// *** logic/bmc_consts.vh ***
// Constants of the bridge miscellaneous control and status register
//
// Summary of operation
// - Writing one to the soft reset bit asserts and holds the reset output.
// - Writing zero to the soft reset bit negates the reset output at once.
// - Local reset input clears the soft reset bit and frees the reset output.
// - PCI reset clears the soft reset bit; output held until PCI reset ends.
// - Grant selects: 0 samples the input asynchronously, 1 synchronously.
// - Grant select bits reset to 0 for first master protocol, else to 1.
// - Byte-order bit: 0 big, 1 little endian on slave, target and DMA paths.
// - A set endian-invert bit on a path uses the inverse byte order.
// - Register-channel data is never swapped; bit 31 stays on bit 31.
// - Mapping-off bit 0: a PCI master-abort ends as a local bus error.
// - Map-off 1: master-abort ends normally; writes flushed, reads all ones.
// - Map-off set: target-abort is an error only with target-abort enable.
// - Prefetch bytes are four times the six-bit count; count resets to one.
// - Host-mode field takes burst pin (upper), size-one pin (lower) on the first edge after reset.
// - Master 00,01 first, 10 second, 11 third; odd codes pair first, third.
`ifndef BMC_CONSTS_VH
`define BMC_CONSTS_VH

// ****************************************************************
// Register address
// ****************************************************************
`define BMC_ADDR_W 12
`define BMC_MISC_OFFSET 12'h800

// ****************************************************************
// Field positions
// ****************************************************************
`define BMC_SOFT_RESET_BIT 31
`define BMC_SYNC_GRANT_BIT 19
`define BMC_SYNC_ACK_BIT 18
`define BMC_BYTE_ORDER_BIT 16
`define BMC_MA_MAP_OFF_BIT 12
`define BMC_FIFO_BLOCK_BIT 9
`define BMC_FIFO_MODE_BIT 8
`define BMC_PREFETCH_HI 7
`define BMC_PREFETCH_LO 2
`define BMC_HOST_MODE_HI 1
`define BMC_HOST_MODE_LO 0

// ****************************************************************
// Reset values
// ****************************************************************
`define BMC_PREFETCH_RESET 6'h01
`define BMC_HOST_MODE_RESET 2'h0

// ****************************************************************
// Data path codes
// ****************************************************************
`define BMC_PATH_SLAVE 2'h0
`define BMC_PATH_TARGET 2'h1
`define BMC_PATH_DMA 2'h2
`define BMC_PATH_REGISTER 2'h3

`endif

// *** logic/bmc_grant_sampler.v ***
// Grant input sampler with selectable synchronous or asynchronous capture
`timescale 1ns/10ps
`default_nettype none
`include "bmc_consts.vh"

module bmc_grant_sampler (
  input wire mclk,
  input wire nrst,
  input wire sync_mode,
  input wire pin_n,
  output reg seen_n
);

  reg meta_n;
  reg stable_n;

  // Two-stage path for a pin on another clock
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      meta_n <= 1'b1;
      stable_n <= 1'b1;
    end else begin
      meta_n <= pin_n;
      stable_n <= meta_n;
    end
  end

  // Synchronous mode saves two cycles of latency
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      seen_n <= 1'b1;
    end else begin
      seen_n <= sync_mode ? pin_n : stable_n;
    end
  end

endmodule // bmc_grant_sampler
`default_nettype wire

// *** logic/bmc_byte_lane.v ***
// Byte lane steering for the local bus data paths
`timescale 1ns/10ps
`default_nettype none
`include "bmc_consts.vh"

module bmc_byte_lane (
  input wire [1:0] path,
  input wire order_little,
  input wire invert,
  input wire [31:0] data_in,
  output reg [31:0] data_out
);

  function [31:0] bmc_swap;
    input [31:0] d;
    begin
      bmc_swap = {d[7:0], d[15:8], d[23:16], d[31:24]};
    end
  endfunction

  reg eff_little;

  always @* begin
    eff_little = order_little ^ invert;
    if (path == `BMC_PATH_REGISTER) begin
      data_out = data_in;
    end else if (eff_little) begin
      data_out = bmc_swap(data_in);
    end else begin
      data_out = data_in;
    end
  end

endmodule // bmc_byte_lane
`default_nettype wire

// *** logic/bmc_misc_control_status.v ***
// Miscellaneous control and status register of the bus bridge
`timescale 1ns/10ps
`default_nettype none
`include "bmc_consts.vh"

module bmc_misc_control_status (
  input wire mclk,
  input wire nrst,
  // Register port
  input wire reg_wr,
  input wire reg_rd,
  input wire [`BMC_ADDR_W-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  output reg [31:0] reg_rdata,
  output reg reg_ack,
  // Resets
  input wire pci_rst_n,
  input wire local_reset_in_n,
  output reg local_reset_out_n,
  // Straps
  input wire burst_in_progress_pin_n,
  input wire transfer_size_pin_one,
  // Grant inputs
  input wire bus_grant_in_n,
  input wire grant_ack_in_n,
  output wire bus_grant_seen_n,
  output wire grant_ack_seen_n,
  // Data path
  input wire dp_valid,
  input wire [1:0] dp_path,
  input wire dp_invert,
  input wire [31:0] dp_data,
  output reg dp_out_valid,
  output reg [31:0] dp_out_data,
  // Abort mapping
  input wire target_abort_map_en,
  input wire abort_valid,
  input wire abort_is_target,
  input wire abort_is_read,
  output reg term_valid,
  output reg term_bus_error,
  output reg term_flush,
  output reg term_read_ones,
  // Configuration views
  output reg [7:0] prefetch_bytes,
  output reg [1:0] host_mode_strap,
  output reg local_byte_order,
  output reg fifo_block_cfg,
  output reg fifo_mode_cfg
);

  // ****************************************************************
  // Register state
  // ****************************************************************
  reg soft_reset_ctl;
  reg sync_grant_sel;
  reg sync_grant_ack_sel;
  reg master_abort_map_off;
  reg [5:0] prefetch_word_count;
  reg strap_taken;

  wire hit;
  wire wr_hit;
  wire local_rst_active;
  wire pci_rst_active;
  wire [31:0] lane_data;
  reg [31:0] read_word;

  assign hit = (reg_addr == `BMC_MISC_OFFSET);
  assign wr_hit = reg_wr & hit;
  assign local_rst_active = ~local_reset_in_n;
  assign pci_rst_active = ~pci_rst_n;

  // ****************************************************************
  // Host mode decoding
  // ****************************************************************
  // One-hot codes of the three master protocols
  localparam [2:0] PROTO_FIRST = 3'h1;
  localparam [2:0] PROTO_SECOND = 3'h2;
  localparam [2:0] PROTO_THIRD = 3'h4;

  // Upper bit is the burst pin level, lower bit the size pin
  wire [1:0] strap_code;

  assign strap_code = {burst_in_progress_pin_n, transfer_size_pin_one};

  function [2:0] bmc_master_proto;
    input [1:0] code;
    begin
      case (code)
        2'h2: begin
          bmc_master_proto = PROTO_SECOND;
        end
        2'h3: begin
          bmc_master_proto = PROTO_THIRD;
        end
        default: begin
          bmc_master_proto = PROTO_FIRST;
        end
      endcase
    end
  endfunction

  // Only the first protocol has its grants on another clock
  function bmc_sync_default;
    input [1:0] code;
    begin
      bmc_sync_default = (bmc_master_proto(code) != PROTO_FIRST);
    end
  endfunction

  // ****************************************************************
  // Soft reset control
  // ****************************************************************
  // Resets beat a write in the same cycle; they end the soft reset state
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      soft_reset_ctl <= 1'b0;
    end else if (local_rst_active) begin
      soft_reset_ctl <= 1'b0;
    end else if (pci_rst_active) begin
      soft_reset_ctl <= 1'b0;
    end else if (wr_hit) begin
      soft_reset_ctl <= reg_wdata[`BMC_SOFT_RESET_BIT];
    end
  end

  // Output follows next state, so it moves on the same edge as the bit; PCI reset instead holds it low
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      local_reset_out_n <= 1'b1;
    end else if (pci_rst_active) begin
      local_reset_out_n <= 1'b0;
    end else if (local_rst_active) begin
      local_reset_out_n <= 1'b1;
    end else if (wr_hit) begin
      local_reset_out_n <= ~reg_wdata[`BMC_SOFT_RESET_BIT];
    end else begin
      local_reset_out_n <= ~soft_reset_ctl;
    end
  end

  // ****************************************************************
  // Strap capture and grant sampling selects
  // ****************************************************************
  // Pins are caught on the first edge after release, not in reset
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      strap_taken <= 1'b0;
      host_mode_strap <= `BMC_HOST_MODE_RESET;
      sync_grant_sel <= 1'b0;
      sync_grant_ack_sel <= 1'b0;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      host_mode_strap <= strap_code;
      sync_grant_sel <= bmc_sync_default(strap_code);
      sync_grant_ack_sel <= bmc_sync_default(strap_code);
    end else if (wr_hit) begin
      sync_grant_sel <= reg_wdata[`BMC_SYNC_GRANT_BIT];
      sync_grant_ack_sel <= reg_wdata[`BMC_SYNC_ACK_BIT];
    end
  end

  // ****************************************************************
  // Plain read/write fields
  // ****************************************************************
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      local_byte_order <= 1'b0;
      master_abort_map_off <= 1'b0;
      fifo_block_cfg <= 1'b0;
      fifo_mode_cfg <= 1'b0;
      prefetch_word_count <= `BMC_PREFETCH_RESET;
    end else if (wr_hit) begin
      local_byte_order <= reg_wdata[`BMC_BYTE_ORDER_BIT];
      master_abort_map_off <= reg_wdata[`BMC_MA_MAP_OFF_BIT];
      // Stored as written; only zero is a supported setting
      fifo_block_cfg <= reg_wdata[`BMC_FIFO_BLOCK_BIT];
      fifo_mode_cfg <= reg_wdata[`BMC_FIFO_MODE_BIT];
      prefetch_word_count <=
        reg_wdata[`BMC_PREFETCH_HI:`BMC_PREFETCH_LO];
    end
  end

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      prefetch_bytes <= {`BMC_PREFETCH_RESET, 2'b00};
    end else if (wr_hit) begin
      prefetch_bytes <=
        {reg_wdata[`BMC_PREFETCH_HI:`BMC_PREFETCH_LO], 2'b00};
    end else begin
      prefetch_bytes <= {prefetch_word_count, 2'b00};
    end
  end

  // ****************************************************************
  // Register read
  // ****************************************************************
  always @* begin
    read_word = 32'h0000_0000;
    read_word[`BMC_SOFT_RESET_BIT] = soft_reset_ctl;
    read_word[`BMC_SYNC_GRANT_BIT] = sync_grant_sel;
    read_word[`BMC_SYNC_ACK_BIT] = sync_grant_ack_sel;
    read_word[`BMC_BYTE_ORDER_BIT] = local_byte_order;
    read_word[`BMC_MA_MAP_OFF_BIT] = master_abort_map_off;
    read_word[`BMC_FIFO_BLOCK_BIT] = fifo_block_cfg;
    read_word[`BMC_FIFO_MODE_BIT] = fifo_mode_cfg;
    read_word[`BMC_PREFETCH_HI:`BMC_PREFETCH_LO] = prefetch_word_count;
    read_word[`BMC_HOST_MODE_HI:`BMC_HOST_MODE_LO] = host_mode_strap;
  end

  // One-cycle answer; unmapped addresses read zero and still answer
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reg_ack <= 1'b0;
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_ack <= reg_wr | reg_rd;
      if (reg_rd && hit) begin
        reg_rdata <= read_word;
      end else begin
        reg_rdata <= 32'h0000_0000;
      end
    end
  end

  // ****************************************************************
  // Grant samplers
  // ****************************************************************
  wire [1:0] grant_sync;
  wire [1:0] grant_pin_n;
  wire [1:0] grant_seen_n;
  genvar g;

  assign grant_sync = {sync_grant_ack_sel, sync_grant_sel};
  assign grant_pin_n = {grant_ack_in_n, bus_grant_in_n};
  assign bus_grant_seen_n = grant_seen_n[0];
  assign grant_ack_seen_n = grant_seen_n[1];

  // Both grant inputs share one sampler design
  generate
    for (g = 0; g < 2; g = g + 1) begin : gen_grant
      bmc_grant_sampler u_sampler (
        .mclk(mclk),
        .nrst(nrst),
        .sync_mode(grant_sync[g]),
        .pin_n(grant_pin_n[g]),
        .seen_n(grant_seen_n[g])
      );
    end
  endgenerate

  // ****************************************************************
  // Byte ordering on the data paths
  // ****************************************************************
  bmc_byte_lane u_lane (
    .path(dp_path),
    .order_little(local_byte_order),
    .invert(dp_invert),
    .data_in(dp_data),
    .data_out(lane_data)
  );

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dp_out_valid <= 1'b0;
      dp_out_data <= 32'h0000_0000;
    end else begin
      dp_out_valid <= dp_valid;
      if (dp_valid) begin
        dp_out_data <= lane_data;
      end
    end
  end

  // ****************************************************************
  // Abort termination mapping
  // ****************************************************************
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      term_valid <= 1'b0;
      term_bus_error <= 1'b0;
      term_flush <= 1'b0;
      term_read_ones <= 1'b0;
    end else begin
      term_valid <= abort_valid;
      term_bus_error <= 1'b0;
      term_flush <= 1'b0;
      term_read_ones <= 1'b0;
      if (abort_valid) begin
        if (!master_abort_map_off) begin
          term_bus_error <= 1'b1;
        end else if (abort_is_target && target_abort_map_en) begin
          term_bus_error <= 1'b1;
        end else begin
          // Normal end: drop posted write data or return all ones
          term_flush <= ~abort_is_read;
          term_read_ones <= abort_is_read;
        end
      end
    end
  end

endmodule // bmc_misc_control_status
`default_nettype wire

// *** verif/bmc_misc_sva.sv ***
// Port checker for the miscellaneous control register
`timescale 1ns/10ps
`default_nettype none
`include "bmc_consts.vh"
module bmc_misc_sva (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [`BMC_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_ack,
  input wire logic pci_rst_n,
  input wire logic local_reset_in_n,
  input wire logic local_reset_out_n,
  input wire logic dp_valid,
  input wire logic [1:0] dp_path,
  input wire logic dp_invert,
  input wire logic [31:0] dp_data,
  input wire logic dp_out_valid,
  input wire logic [31:0] dp_out_data,
  input wire logic local_byte_order,
  input wire logic abort_valid,
  input wire logic term_valid,
  input wire logic [7:0] prefetch_bytes
);
  // ****
  // Checks
  // ****
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  wire logic hit = reg_wr && reg_addr == `BMC_MISC_OFFSET;
  soft_set_a: assert property (
    hit && reg_wdata[31] && local_reset_in_n |=> !local_reset_out_n)
    else $error("soft reset did not drive output");
  soft_clr_a: assert property (
    hit && !reg_wdata[31] && pci_rst_n |=> local_reset_out_n)
    else $error("soft reset clear did not free output");
  local_in_a: assert property (
    !local_reset_in_n && pci_rst_n |=> local_reset_out_n)
    else $error("local reset input left output low");
  pci_hold_a: assert property (
    !pci_rst_n |=> !local_reset_out_n)
    else $error("output released during pci reset");
  prefetch_wr_a: assert property (
    hit |=> prefetch_bytes == {$past(reg_wdata[7:2]), 2'h0})
    else $error("prefetch bytes wrong");
  order_wr_a: assert property (
    hit |=> local_byte_order == $past(reg_wdata[16]))
    else $error("byte order copy wrong");
  reg_path_a: assert property (
    dp_valid && dp_path == 2'h3
    |=> dp_out_valid && dp_out_data == $past(dp_data))
    else $error("register path altered");
  byte_swap_a: assert property (
    dp_valid && dp_path != 2'h3 && (local_byte_order ^ dp_invert)
    |=> dp_out_data == {$past(dp_data[7:0]), $past(dp_data[15:8]),
    $past(dp_data[23:16]), $past(dp_data[31:24])})
    else $error("swapped path wrong");
  unmapped_read_a: assert property (
    reg_rd && reg_addr != `BMC_MISC_OFFSET |=> reg_ack && reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  abort_term_a: assert property (
    abort_valid |=> term_valid)
    else $error("abort not terminated");
endmodule // bmc_misc_sva
`default_nettype wire

// *** verif/bmc_host_model.sv ***
// Host side model issuing single word register accesses
`timescale 1ns/10ps
`default_nettype none
module bmc_host_model (
  input wire logic mclk,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_ack,
  output logic reg_wr,
  output logic reg_rd,
  output logic [11:0] reg_addr,
  output logic [31:0] reg_wdata
);
  int n_xfer = 0;
  int n_ack = 0;
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 12'h0;
    reg_wdata = 32'h0;
  end
  // ****
  // One access, started just after an edge
  // ****
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] q);
    reg_wr = w;
    reg_rd = !w;
    reg_addr = a;
    reg_wdata = w ? d & ~32'h300 : ~reg_wdata;
    @(posedge mclk);
    #1;
    // Strobes are one-cycle pulses; the answer stands one cycle later
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    // Idle bus shows inverted values so stale data is never trusted
    reg_addr = ~a;
    reg_wdata = ~reg_wdata;
    @(posedge mclk);
    n_xfer++;
    if (reg_ack === 1'b1)
      n_ack++;
    q = reg_rdata;
    #1;
  endtask
endmodule // bmc_host_model
`default_nettype wire

// *** verif/tb_top.sv ***
// Self-checking bench for the miscellaneous control register
`timescale 1ns/10ps
`default_nettype none
`include "bmc_consts.vh"
module tb_top;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic pci_rst_n, local_reset_in_n, burst_in_progress_pin_n;
  logic transfer_size_pin_one, bus_grant_in_n, grant_ack_in_n;
  logic dp_valid, dp_invert, target_abort_map_en;
  logic abort_valid, abort_is_target, abort_is_read;
  logic [1:0] dp_path;
  logic [31:0] dp_data, q;
  logic [3:0] msk;
  logic [31:0] seed = 32'd74;
  wire logic reg_wr, reg_rd, reg_ack, local_reset_out_n;
  wire logic [11:0] reg_addr;
  wire logic [31:0] reg_wdata, reg_rdata, dp_out_data;
  wire logic bus_grant_seen_n, grant_ack_seen_n, dp_out_valid;
  wire logic term_valid, term_bus_error, term_flush, term_read_ones;
  wire logic [3:0] term_bits = {term_valid, term_bus_error, term_flush,
    term_read_ones};
  wire logic [7:0] prefetch_bytes;
  wire logic [1:0] host_mode_strap;
  wire logic local_byte_order, fifo_block_cfg, fifo_mode_cfg;
  int n_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  bmc_host_model i_host (.mclk, .reg_rdata, .reg_ack, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata);
  bmc_misc_control_status i_dut (.mclk, .nrst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .reg_ack, .pci_rst_n, .local_reset_in_n, .local_reset_out_n,
    .burst_in_progress_pin_n, .transfer_size_pin_one, .bus_grant_in_n,
    .grant_ack_in_n, .bus_grant_seen_n, .grant_ack_seen_n, .dp_valid,
    .dp_path, .dp_invert, .dp_data, .dp_out_valid, .dp_out_data,
    .target_abort_map_en, .abort_valid, .abort_is_target, .abort_is_read,
    .term_valid, .term_bus_error, .term_flush, .term_read_ones,
    .prefetch_bytes, .host_mode_strap, .local_byte_order, .fifo_block_cfg,
    .fifo_mode_cfg);
  always #10 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors = n_errors + 1;
      conclude();
    end
  end
  // ****
  // Helpers
  // ****
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] exp_dp(input logic [31:0] d,
    input logic [1:0] p, input logic sw);
    return (p == 2'h3 || !sw) ? d : {d[7:0], d[15:8], d[23:16], d[31:24]};
  endfunction
  function automatic logic [3:0] exp_ab(input logic [3:0] k);
    logic be;
    be = !k[3] || (k[0] && k[2]);
    return {1'b1, be, !be && !k[1], !be && k[1]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic conclude;
    if (n_errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ****
  // Main sequence
  // ****
  initial begin
    pci_rst_n = 1'b1;
    local_reset_in_n = 1'b1;
    burst_in_progress_pin_n = 1'b1;
    transfer_size_pin_one = 1'b1;
    bus_grant_in_n = 1'b1;
    grant_ack_in_n = 1'b1;
    {dp_valid, dp_invert, dp_path, dp_data} = 36'h0;
    {target_abort_map_en, abort_valid, abort_is_target} = 3'h0;
    abort_is_read = 1'b0;
    for (int m = 0; m < 4; m++) begin
      nrst = 1'b0;
      {burst_in_progress_pin_n, transfer_size_pin_one} = m[1:0];
      tick(8);
      nrst = 1'b1;
      tick(2);
      i_host.xfer(1'b0, `BMC_MISC_OFFSET, 32'h0, q);
      chk("reset", {12'h0, {2{m[1]}}, 16'h1, m[1:0]}, q);
      chk("strap", m, {30'h0, host_mode_strap});
    end
    for (int s = 1; s >= 0; s--) begin
      i_host.xfer(1'b1, `BMC_MISC_OFFSET, {12'h0, {2{s[0]}}, 18'h0}, q);
      {bus_grant_in_n, grant_ack_in_n} = 2'h0;
      tick(s ? 0 : 2);
      chk("grant early", 3, {bus_grant_seen_n, grant_ack_seen_n});
      tick(1);
      chk("grant seen", 0, {bus_grant_seen_n, grant_ack_seen_n});
      {bus_grant_in_n, grant_ack_in_n} = 2'h3;
      tick(4);
    end
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      i_host.xfer(1'b1, `BMC_MISC_OFFSET, seed, q);
      i_host.xfer(1'b0, `BMC_MISC_OFFSET, 32'h0, q);
      chk("readback", (seed & 32'h800d10fc) | 32'h3, q);
      chk("prefetch", {seed[7:2], 2'h0}, prefetch_bytes);
      chk("reset out", !seed[31], local_reset_out_n);
      chk("fifo cfg", 0, {fifo_block_cfg, fifo_mode_cfg});
    end
    i_host.xfer(1'b1, 12'h804, 32'hffffffff, q);
    i_host.xfer(1'b0, 12'h804, 32'h0, q);
    chk("unmapped", 0, q);
    i_host.xfer(1'b1, `BMC_MISC_OFFSET, 32'h80000000, q);
    chk("soft on", 0, local_reset_out_n);
    // Driven on its own, never looped back from the output
    local_reset_in_n = 1'b0;
    tick(1);
    local_reset_in_n = 1'b1;
    chk("local in", 1, local_reset_out_n);
    i_host.xfer(1'b0, `BMC_MISC_OFFSET, 32'h0, q);
    chk("soft cleared", 0, q[31]);
    i_host.xfer(1'b1, `BMC_MISC_OFFSET, 32'h80000000, q);
    pci_rst_n = 1'b0;
    tick(3);
    chk("pci hold", 0, local_reset_out_n);
    i_host.xfer(1'b0, `BMC_MISC_OFFSET, 32'h0, q);
    chk("pci clear", 0, q[31]);
    pci_rst_n = 1'b1;
    tick(1);
    chk("pci end", 1, local_reset_out_n);
    for (int j = 0; j < 16; j++) begin
      if (j[2:0] == 0)
        i_host.xfer(1'b1, `BMC_MISC_OFFSET, {15'h0, j[3], 16'h0}, q);
      seed = lfsr(seed);
      dp_valid = 1'b1;
      {dp_invert, dp_path} = j[2:0];
      dp_data = seed;
      tick(1);
      chk("dp", exp_dp(seed, j[1:0], j[3] ^ j[2]), dp_out_data);
      chk("dp valid", 1, dp_out_valid);
    end
    dp_valid = 1'b0;
    tick(1);
    chk("dp idle", 0, dp_out_valid);
    for (int k = 0; k < 16; k++) begin
      if (k[2:0] == 0)
        i_host.xfer(1'b1, `BMC_MISC_OFFSET, {19'h0, k[3], 12'h0}, q);
      abort_valid = 1'b1;
      {target_abort_map_en, abort_is_read, abort_is_target} = k[2:0];
      msk = k[0] ? 4'hc : 4'hf;
      tick(1);
      chk("abort", exp_ab(k[3:0]) & msk, term_bits & msk);
    end
    abort_valid = 1'b0;
    tick(2);
    chk("acks", i_host.n_xfer, i_host.n_ack);
    conclude();
  end
endmodule // tb_top
bind bmc_misc_control_status bmc_misc_sva i_sva (.mclk, .nrst, .reg_wr, .reg_rd,
  .reg_addr, .reg_wdata, .reg_rdata, .reg_ack, .pci_rst_n, .local_reset_in_n,
  .local_reset_out_n, .dp_valid, .dp_path, .dp_invert, .dp_data,
  .dp_out_valid, .dp_out_data, .local_byte_order, .abort_valid, .term_valid,
  .prefetch_bytes);
`default_nettype wire
